/* File: hw/cvsd_defs.svh */
/*
 Constants of the delta codec: widths, filter time constants, scale thresholds.
 Assumes it is included by the package and by each design file; the guard keeps it single.
*/
`ifndef CVSD_DEFS_SVH
`define CVSD_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define CVSD_AUDIO_W 12
`define CVSD_FRAC_W 8
`define CVSD_ACC_W 20
`define CVSD_STEP_W 16

// ----------------------------------------------------------------------
// Nominal bit rates (kbit/s) and time constants (us)
// ----------------------------------------------------------------------
`define CVSD_RATE_16_KBPS 32'h10
`define CVSD_RATE_32_KBPS 32'h20
// 4000 us
`define CVSD_SYL_TC_US 32'hFA0
// 940 us and 470 us
`define CVSD_RECON_TC_16_US 32'h3AC
`define CVSD_RECON_TC_32_US 32'h1D6
`define CVSD_US_PER_MS 32'h3E8

// ----------------------------------------------------------------------
// Amplitude, in units of 0.1 percent of supply; full scale is 500 units
// ----------------------------------------------------------------------
`define CVSD_RES_16_UNITS 32'h1
`define CVSD_RES_32_UNITS 32'h2
`define CVSD_MIN_STEP_MULT 32'h2
// Step size ratio: 24 dB is a factor of 16, 18 dB a factor of 8
`define CVSD_RATIO_16 32'h10
`define CVSD_RATIO_32 32'h8
// Half scale 250 units, three-quarter scale 375 units
`define CVSD_HALF_SCALE 12'h0FA
`define CVSD_CLAMP_SCALE 12'h177

`endif

/* File: hw/cvsd_pkg.sv */
/*
 Types and shared arithmetic of the delta codec.
 Assumes cvsd_defs.svh is on the include path.
*/
package cvsd_pkg;
`include "cvsd_defs.svh"

   typedef enum logic {
      MODE_ENCODE = 1'b0,
      MODE_DECODE = 1'b1
   } codec_mode_t;

   typedef logic signed [`CVSD_AUDIO_W-1:0] sample_t;
   typedef logic [`CVSD_STEP_W-1:0] step_t;
   typedef logic signed [`CVSD_ACC_W-1:0] acc_t;

   typedef struct packed {
      step_t step;
   } syl_state_t;

   typedef struct packed {
      acc_t acc;
      logic clamp;
   } integ_state_t;

   typedef struct packed {
      logic bclk;
      logic [1:0] hist;
      logic bit_d;
      logic tx;
      logic quiet_ph;
      sample_t audio;
      logic flag_n;
      logic clamp;
   } codec_state_t;

   // Time constant expressed in bit periods, rounded to nearest
   function automatic int unsigned tc_bits(input int unsigned tc_us, input int unsigned kbps);
      return (tc_us * kbps + (`CVSD_US_PER_MS / 2)) / `CVSD_US_PER_MS;
   endfunction

   function automatic int unsigned log2_ceil(input int unsigned v);
      int unsigned r;
      r = 0;
      while ((32'h1 << r) < v) r = r + 1;
      return r;
   endfunction

   // Magnitude; inputs never reach the most negative code because of the clamp
   function automatic sample_t mag(input sample_t v);
      return (v < 0) ? -v : v;
   endfunction

endpackage

/* File: hw/syllabic_filter.sv */
/*
 Syllabic filter: step size that grows during bit runs and decays otherwise.
 Assumes step_en_i is a one-cycle pulse per bit period and clear_i a level.
*/
`include "cvsd_defs.svh"
module syllabic_filter #(
   parameter bit VARIANT_32K = 1'b0
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic clear_i,
   input wire logic step_en_i,
   input wire logic coinc_i,
   output cvsd_pkg::step_t step_o
);
   import cvsd_pkg::*;

   localparam int unsigned RATE = VARIANT_32K ? `CVSD_RATE_32_KBPS : `CVSD_RATE_16_KBPS;
   localparam int unsigned RES = VARIANT_32K ? `CVSD_RES_32_UNITS : `CVSD_RES_16_UNITS;
   localparam int unsigned RATIO = VARIANT_32K ? `CVSD_RATIO_32 : `CVSD_RATIO_16;
   localparam step_t MIN_STEP = step_t'((RES * `CVSD_MIN_STEP_MULT) << `CVSD_FRAC_W);
   localparam step_t MAX_STEP = step_t'(MIN_STEP * RATIO);
   localparam int unsigned SHIFT = log2_ceil(tc_bits(`CVSD_SYL_TC_US, RATE));

   syl_state_t s_r;
   syl_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (clear_i) begin
         s_nxt.step = MIN_STEP;
      end else if (step_en_i) begin
         if (coinc_i) begin
            s_nxt.step = s_r.step + ((MAX_STEP - s_r.step) >> SHIFT);
         end else begin
            s_nxt.step = s_r.step - ((s_r.step - MIN_STEP) >> SHIFT);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '{step: MIN_STEP};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign step_o = s_r.step;
endmodule

/* File: hw/recon_integrator.sv */
/*
 Leaky reconstruction integrator with symmetric clamp at three-quarter scale.
 Assumes step_en_i is a one-cycle pulse per bit period and clear_i a level.
*/
`include "cvsd_defs.svh"
module recon_integrator #(
   parameter bit VARIANT_32K = 1'b0
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic clear_i,
   input wire logic step_en_i,
   input wire logic bit_i,
   input wire cvsd_pkg::step_t step_i,
   output cvsd_pkg::sample_t est_o,
   output logic clamp_o
);
   import cvsd_pkg::*;

   localparam int unsigned RATE = VARIANT_32K ? `CVSD_RATE_32_KBPS : `CVSD_RATE_16_KBPS;
   localparam int unsigned TC_US = VARIANT_32K ? `CVSD_RECON_TC_32_US : `CVSD_RECON_TC_16_US;
   localparam int unsigned SHIFT = log2_ceil(tc_bits(TC_US, RATE));
   localparam acc_t LIMIT = acc_t'(`CVSD_CLAMP_SCALE) <<< `CVSD_FRAC_W;

   integ_state_t s_r;
   integ_state_t s_nxt;
   acc_t delta;
   acc_t cand;

   always_comb begin
      s_nxt = s_r;
      delta = bit_i ? acc_t'(step_i) : -acc_t'(step_i);
      cand = s_r.acc + delta - (s_r.acc >>> SHIFT);
      if (clear_i) begin
         s_nxt.acc = '0;
         s_nxt.clamp = 1'b0;
      end else if (step_en_i) begin
         if (cand >= LIMIT) begin
            s_nxt.acc = LIMIT;
            s_nxt.clamp = 1'b1;
         end else if (cand <= -LIMIT) begin
            s_nxt.acc = -LIMIT;
            s_nxt.clamp = 1'b1;
         end else begin
            s_nxt.acc = cand;
            s_nxt.clamp = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign est_o = s_r.acc[`CVSD_ACC_W-1:`CVSD_FRAC_W];
   assign clamp_o = s_r.clamp;
endmodule

/* File: hw/cvsd_delta_codec.sv */
/*
 Half-duplex slope-adaptive delta codec: encodes samples into a serial NRZ stream
 or decodes a received stream back into samples.
 Assumes all inputs, the bit clock among them, are synchronous to clk_i, and the
 bit clock is much slower than clk_i (at least four clk_i periods per phase).
*/
`include "cvsd_defs.svh"
module cvsd_delta_codec #(
   parameter bit VARIANT_32K = 1'b0
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic bit_clk_i,
   input wire cvsd_pkg::codec_mode_t mode_i,
   input wire logic alt_text_force_n_i,
   input wire logic zero_force_n_i,
   input wire logic data_rx_i,
   input wire cvsd_pkg::sample_t audio_in_i,
   output logic data_tx_o,
   output cvsd_pkg::sample_t audio_out_o,
   output logic level_flag_n_o,
   output logic clamp_o
);
   import cvsd_pkg::*;

   // ----------------------------------------------------------------------
   // Scale constants
   // ----------------------------------------------------------------------
   // Quiet amplitude
   localparam sample_t RES = sample_t'(VARIANT_32K ? `CVSD_RES_32_UNITS : `CVSD_RES_16_UNITS);

   codec_state_t s_r;
   codec_state_t s_nxt;

   logic rise;
   logic fall;
   logic quiet;
   logic tx_quiet;
   logic bit_now;
   logic coinc;
   logic step_en;
   logic integ_clamp;
   step_t step;
   sample_t est;

   // ----------------------------------------------------------------------
   // Bit-clock edges and bit decision
   // ----------------------------------------------------------------------
   // One decision per bit period
   assign rise = bit_clk_i & ~s_r.bclk;
   assign fall = ~bit_clk_i & s_r.bclk;

   assign quiet = ~zero_force_n_i;

   // Decode mode keeps the transmit line idle since the channel is half duplex
   assign tx_quiet = quiet | ~alt_text_force_n_i | (mode_i == MODE_DECODE);

   always_comb begin
      if (mode_i == MODE_DECODE) begin
         bit_now = data_rx_i;
      end else begin
         bit_now = (audio_in_i > est);
      end
   end

   assign coinc = (bit_now == s_r.hist[0]) && (bit_now == s_r.hist[1]);

   assign step_en = rise & ~quiet;

   // ----------------------------------------------------------------------
   // Filters
   // ----------------------------------------------------------------------
   // Time constants in bit periods
   syllabic_filter #(
      .VARIANT_32K(VARIANT_32K)
   ) u_syllabic (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .clear_i(quiet),
      .step_en_i(step_en),
      .coinc_i(coinc),
      .step_o(step)
   );

   recon_integrator #(
      .VARIANT_32K(VARIANT_32K)
   ) u_integ (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .clear_i(quiet),
      .step_en_i(step_en),
      .bit_i(bit_now),
      .step_i(step),
      .est_o(est),
      .clamp_o(integ_clamp)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.bclk = bit_clk_i;
      if (quiet) begin
         // Alternating history so the first bit after release forms no run
         s_nxt.hist = 2'h1;
         s_nxt.bit_d = 1'b0;
      end else if (rise) begin
         s_nxt.hist = {s_r.hist[0], bit_now};
         s_nxt.bit_d = bit_now;
      end
      if (fall) begin
         s_nxt.quiet_ph = ~s_r.quiet_ph;
         if (tx_quiet) begin
            s_nxt.tx = ~s_r.quiet_ph;
         end else begin
            s_nxt.tx = s_r.bit_d;
         end
      end
      if (quiet) begin
         s_nxt.audio = s_r.quiet_ph ? RES : -RES;
      end else begin
         s_nxt.audio = est;
      end
      // Half-scale flag
      // Forced quiet drops both flags at once, in step with the quiet audio
      s_nxt.flag_n = quiet | ~(mag(est) >= sample_t'(`CVSD_HALF_SCALE));
      s_nxt.clamp = integ_clamp & ~quiet;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '{bclk: 1'b0, hist: 2'h1, bit_d: 1'b0, tx: 1'b0, quiet_ph: 1'b0,
                  audio: '0, flag_n: 1'b1, clamp: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign data_tx_o = s_r.tx;
   assign audio_out_o = s_r.audio;
   assign level_flag_n_o = s_r.flag_n;
   assign clamp_o = s_r.clamp;
endmodule

/* File: bench/cvsd_delta_codec_chk.sv */
/* Port assertions of the delta codec, bound to every instance.
 Assumes cvsd_pkg is compiled before this file. */
`include "cvsd_defs.svh"
module cvsd_delta_codec_chk #(
   parameter bit VARIANT_32K = 1'b0
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic bit_clk_i,
   input wire cvsd_pkg::codec_mode_t mode_i,
   input wire logic alt_text_force_n_i,
   input wire logic zero_force_n_i,
   input wire logic data_rx_i,
   input wire cvsd_pkg::sample_t audio_in_i,
   input wire logic data_tx_o,
   input wire cvsd_pkg::sample_t audio_out_o,
   input wire logic level_flag_n_o,
   input wire logic clamp_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import cvsd_pkg::*;
   localparam sample_t RES = VARIANT_32K ? 12'h002 : 12'h001;
   localparam sample_t TOP = `CVSD_CLAMP_SCALE;
   logic b1_r, q_r, fz_r, ev_r, eb_r, rise, fall, quiet;
   sample_t mg;
   assign rise = bit_clk_i & ~b1_r;
   assign fall = b1_r & ~bit_clk_i;
   assign quiet = ~zero_force_n_i | ~alt_text_force_n_i | (mode_i == MODE_DECODE);
   assign mg = audio_out_o[11] ? -audio_out_o : audio_out_o;
   // q_r stays set only while quiet, fz_r only while zero force, has held since a fall, so a toggle has a known base; ev_r only while not quiet since a rise
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {b1_r, q_r, fz_r, ev_r, eb_r} <= '0;
      end else begin
         b1_r <= bit_clk_i;
         q_r <= quiet & (q_r | fall);
         fz_r <= ~zero_force_n_i & (fz_r | fall);
         ev_r <= ~quiet & (rise | ev_r);
         if (rise) begin
            eb_r <= audio_in_i > audio_out_o;
         end
      end
   end
   // ----------
   // Assertions
   // ----------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   AST_TX_EDGE: assert property ($changed(data_tx_o) |-> $past(fall))
      else $error("tx moved off a fall");
   AST_QUIET_TGL: assert property (
      fall && q_r && quiet |=> data_tx_o != $past(data_tx_o))
      else $error("quiet tx did not toggle");
   AST_ENC_BIT: assert property (fall && ev_r && !quiet |=> data_tx_o == eb_r)
      else $error("encoded bit wrong");
   AST_FZ_AUDIO: assert property (
      fz_r && !zero_force_n_i |=> zero_force_n_i || audio_out_o == RES || audio_out_o == -RES)
      else $error("forced audio off quiet level");
   AST_FZ_FLAG: assert property (fz_r && !zero_force_n_i |=> level_flag_n_o && !clamp_o)
      else $error("forced state kept flag");
   AST_FLAG: assert property (
      zero_force_n_i |-> level_flag_n_o == (mg < `CVSD_HALF_SCALE))
      else $error("level flag wrong");
   AST_CLAMP: assert property (clamp_o |-> mg == TOP)
      else $error("clamp off scale");
   AST_RANGE: assert property (mg <= TOP)
      else $error("audio beyond clamp");
   AST_AUD_TIME: assert property (
      $changed(audio_out_o) && $past(zero_force_n_i) && $past(zero_force_n_i, 2)
      && $past(zero_force_n_i, 3) |-> $past(rise, 2))
      else $error("audio moved off a rise");
   cover property (fall && q_r && quiet);
   cover property (rise && !quiet);
   cover property ($rose(clamp_o));
endmodule

bind cvsd_delta_codec cvsd_delta_codec_chk #(.VARIANT_32K(VARIANT_32K)) chk (
   .clk_i(clk_i), .rstn_i(rstn_i), .bit_clk_i(bit_clk_i), .mode_i(mode_i),
   .alt_text_force_n_i(alt_text_force_n_i), .zero_force_n_i(zero_force_n_i),
   .data_rx_i(data_rx_i), .audio_in_i(audio_in_i), .data_tx_o(data_tx_o),
   .audio_out_o(audio_out_o), .level_flag_n_o(level_flag_n_o), .clamp_o(clamp_o));

/* File: bench/cvsd_channel_model.sv */
/* Channel model: makes the bit clock and sends one NRZ bit per period.
 Assumes clk_i is the codec's system clock; HALF keeps each phase long enough. */
module cvsd_channel_model #(
   parameter int HALF = 5
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic send_i,
   output logic bit_clk_o,
   output logic data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r <= 0;
         bit_clk_o <= 1'b0;
         data_o <= 1'b0;
      end else if (cnt_r == HALF - 1) begin
         cnt_r <= 0;
         bit_clk_o <= ~bit_clk_o;
         if (bit_clk_o) data_o <= send_i;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
endmodule

/* File: bench/cvsd_delta_codec_tb.sv */
/* Bench of the delta codec: steady-state table, then forced quiet and reset.
 Assumes package, design, checker and channel model are compiled first. */
`include "cvsd_defs.svh"
module cvsd_delta_codec_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cvsd_pkg::*;
   typedef struct {
      codec_mode_t md;
      logic at_n, snd;
      sample_t ain, aout;
      logic [1:0] tx;
   } row_t;
   localparam sample_t TOP = `CVSD_CLAMP_SCALE;
   localparam sample_t BIG = 12'h190;
   // Rows chain: each starts from the previous row's settled state; tx 2 means toggling
   row_t rows [5] = '{
      '{MODE_ENCODE, 1'b1, 1'b0, BIG, TOP, 2'h1},
      '{MODE_ENCODE, 1'b1, 1'b0, -BIG, -TOP, 2'h0},
      '{MODE_ENCODE, 1'b0, 1'b0, BIG, TOP, 2'h2},
      '{MODE_DECODE, 1'b1, 1'b0, 12'h000, -TOP, 2'h2},
      '{MODE_DECODE, 1'b1, 1'b1, BIG, TOP, 2'h2}};
   logic clk = 1'b0, rstn = 1'b0, at_n = 1'b1, zf_n = 1'b1, snd = 1'b0, t0;
   logic bclk, rx, tx, fl_n, cl;
   codec_mode_t md = MODE_ENCODE;
   sample_t ain = 12'h000, aout, a0;
   int fail_count = 0, total_checks = 0, cyc = 0;
   cvsd_channel_model #(.HALF(5)) chan (.clk_i(clk), .rstn_i(rstn), .send_i(snd),
      .bit_clk_o(bclk), .data_o(rx));
   cvsd_delta_codec #(.VARIANT_32K(1'b0)) uut (.clk_i(clk), .rstn_i(rstn), .bit_clk_i(bclk),
      .mode_i(md), .alt_text_force_n_i(at_n), .zero_force_n_i(zf_n), .data_rx_i(rx),
      .audio_in_i(ain), .data_tx_o(tx), .audio_out_o(aout), .level_flag_n_o(fl_n),
      .clamp_o(cl));
   always #5 clk = ~clk;
   task automatic chk_b(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t bit %b not %b", $time, got, exp);
      end
   endtask
   task automatic chk_s(input sample_t got, input sample_t exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t sample %0d not %0d", $time, got, exp);
      end
   endtask
   // Settle point: three clocks past a bit-clock fall, after tx and audio land
   task automatic bits(input int n);
      repeat (n) @(negedge bclk);
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         print_verdict();
      end
   end
   // -------------
   // Main sequence
   // -------------
   initial begin
      repeat (12) @(posedge clk);
      #1 rstn = 1'b1;
      foreach (rows[i]) begin
         md = rows[i].md;
         at_n = rows[i].at_n;
         snd = rows[i].snd;
         ain = rows[i].ain;
         bits(400);
         t0 = tx;
         bits(1);
         if (rows[i].tx[1]) chk_b(tx, ~t0);
         else chk_b(tx, rows[i].tx[0]);
         chk_s(aout, rows[i].aout);
         chk_b(fl_n, 1'b0);
         chk_b(cl, 1'b1);
      end
      md = MODE_ENCODE;
      zf_n = 1'b0;
      bits(5);
      a0 = aout;
      bits(1);
      chk_s(aout, -a0);
      chk_b(tx, ~aout[11]);
      if (a0[11]) a0 = -a0;
      chk_s(a0, 12'h001);
      chk_b(fl_n, 1'b1);
      chk_b(cl, 1'b0);
      zf_n = 1'b1;
      @(posedge bclk);
      repeat (3) @(posedge clk);
      #1;
      chk_s(aout, 12'h002);
      bits(50);
      rstn = 1'b0;
      #1;
      chk_s(aout, 12'h000);
      chk_b(tx, 1'b0);
      chk_b(fl_n, 1'b1);
      chk_b(cl, 1'b0);
      repeat (12) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk_s(aout, 12'h000);
      print_verdict();
   end
endmodule
